// ### core/wdr_pkg.sv
// Package: constants shared by the watchdog and reset-cause flag block
package wdr_pkg;

  // ---------------------------------------------------------------
  // Register addressing
  // ---------------------------------------------------------------
  localparam logic [6:0] IO_SPACE_TOP = 7'h3F;      // Last direct I/O offset
  localparam logic [6:0] DATA_SPACE_BIAS = 7'h20;   // Data-space address = offset + bias
  localparam logic [6:0] DATA_SPACE_TOP = 7'h5F;    // Last data-space alias of I/O space
  localparam logic [5:0] CTRL_OFFSET = 6'h21;       // watchdog_control
  localparam logic [5:0] FLAGS_OFFSET = 6'h34;      // reset_cause_flags

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CHANGE_ENABLE_BIT = 4;
  localparam int DOG_ENABLE_BIT = 3;
  localparam int TIMEOUT_SELECT_MSB = 2;
  localparam int DOG_RESET_FLAG_BIT = 3;
  localparam int SUPPLY_DROP_FLAG_BIT = 2;
  localparam int PIN_RESET_FLAG_BIT = 1;
  localparam int POWER_UP_FLAG_BIT = 0;
  localparam logic [7:0] CTRL_USED_MASK = 8'h1F;    // Bits 7:5 read zero
  localparam logic [7:0] FLAGS_USED_MASK = 8'h0F;   // Bits 7:4 read zero

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CHANGE_ENABLE_CYCLES = 4;          // Change-enable life in clocks
  localparam int CLK_PERIOD_NS = 8;                 // 125 MHz system clock
  localparam int DOG_OSC_PERIOD_NS = 1000;          // 1 MHz watchdog oscillator
  localparam int DOG_OSC_DIV_CYCLES = (DOG_OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMEOUT_BASE_OSC = 16384;          // Oscillator cycles at select 000
  localparam int TIMEOUT_COUNT_W = 22;              // Holds 2,097,152

endpackage

// ### core/wdr_tick_div.sv
// Divider making the one-cycle watchdog oscillator enable pulse
`timescale 1ns/1ps

module wdr_tick_div #(
  parameter int DIV = 125
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  output logic tick_o
);

  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic next_tick;

  // Free-running divide; the pulse is registered so it is glitch free
  always_comb begin
    next_tick = (count == LAST);
    next_count = next_tick ? '0 : count + CW'(1);
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count <= '0;
      tick_o <= 1'b0;
    end else begin
      count <= next_count;
      tick_o <= next_tick;
    end
  end

endmodule

// ### core/wdr_top.sv
// Watchdog control register, time-out counter and reset-cause flags
`timescale 1ns/1ps

// Overview of operation
// [RL1] Watchdog reset sets flag bit 3; power-on or written zero clears it.
// [RL2] Brown-out reset sets flag bit 2; power-on or written zero clears it.
// [RL3] Pin reset sets flag bit 1; power-on or written zero clears it.
// [RL4] Power-on sets flag bit 0; only a written zero clears it.
// [RL5] Firmware reads then clears the flags early to identify the next reset.
// [RL6] I/O offsets 0x00-0x3F; data-space address adds 0x20.
// [RL7] Flag register at I/O 0x34, data 0x54, resets to 0x00.
// [RL8] Control register at I/O 0x21, data 0x41, resets to 0x00.
// [RL9] Change-enable bit 4 clears itself four clocks after being written one.
// [RL10] Enable bit 3 sets freely; clears only while change-enable is one.
// [RL11] Firmware writes change-enable and enable, then enable zero within four clocks.
// [RL12] Time-out select changes only while change-enable is one.
// [RL13] Select code 000 gives 16,384 oscillator cycles, doubling up to 2,097,152.
// [RL14] Time-out gives a one system clock internal reset pulse.
// [RL15] Count restarts on restart instruction, when disabled, and on chip reset.
// [RL16] Always-on fuse keeps watchdog enabled and enable bit reading one.
// [RL17] Counter runs from a separate nominal 1 MHz oscillator; the model uses a divide-by-OSC_DIV enable from the system clock.
// [RL18] Unused upper bits read zero and ignore writes.
// [RL19] Time-out when oscillator count reaches selected value while enabled.
module wdr_top
  import wdr_pkg::*;
#(
  parameter int TIMEOUT_BASE = TIMEOUT_BASE_OSC,
  parameter int OSC_DIV = DOG_OSC_DIV_CYCLES
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [6:0] io_addr_i,
  input wire logic io_data_space_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  input wire logic power_up_reset_i,
  input wire logic supply_drop_reset_i,
  input wire logic pin_reset_i,
  input wire logic dog_restart_instruction_i,
  input wire logic always_on_fuse_i,
  output logic dog_reset_o,
  output logic dog_enable_o
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  localparam int CE_W = $clog2(CHANGE_ENABLE_CYCLES + 1);
  localparam logic [CE_W-1:0] CE_LOAD = CE_W'(CHANGE_ENABLE_CYCLES - 1);
  localparam logic [TIMEOUT_COUNT_W-1:0] BASE_LIMIT = TIMEOUT_COUNT_W'(TIMEOUT_BASE);

  logic osc_tick;
  logic [5:0] offset;
  logic hit;
  logic ctrl_wr;
  logic flags_wr;
  logic chip_reset;
  logic [TIMEOUT_COUNT_W-1:0] limit;

  logic change_enable;
  logic dog_enable;
  logic [2:0] timeout_select;
  logic [CE_W-1:0] ce_count;
  logic next_change_enable;
  logic next_dog_enable;
  logic [2:0] next_timeout_select;
  logic [CE_W-1:0] next_ce_count;

  logic [3:0] cause_flags;
  logic [3:0] next_cause_flags;

  logic [TIMEOUT_COUNT_W-1:0] dog_count;
  logic [TIMEOUT_COUNT_W-1:0] next_dog_count;
  logic next_dog_reset;

  logic [7:0] next_rdata;
  logic next_dog_enable_o;

  // ---------------------------------------------------------------
  // Watchdog oscillator enable
  // ---------------------------------------------------------------
  // The separate oscillator is modelled as an enable from the system clock,
  // so the time-out tracks the system clock rather than a real RC source
  wdr_tick_div #(
    .DIV(OSC_DIV)
  ) u_osc_div (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .tick_o(osc_tick)
  ); // RL17

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  // Data-space accesses below the bias or above the alias top miss
  always_comb begin
    offset = 6'h00;
    hit = 1'b0;
    if (io_data_space_i) begin
      if ((io_addr_i >= DATA_SPACE_BIAS) && (io_addr_i <= DATA_SPACE_TOP)) begin
        offset = 6'(io_addr_i - DATA_SPACE_BIAS); // RL6
        hit = 1'b1;
      end
    end else if (io_addr_i <= IO_SPACE_TOP) begin
      offset = io_addr_i[5:0]; // RL6
      hit = 1'b1;
    end
  end

  assign ctrl_wr = io_wr_i && hit && (offset == CTRL_OFFSET); // RL8
  assign flags_wr = io_wr_i && hit && (offset == FLAGS_OFFSET); // RL7

  // Any reset source restarts the watchdog and its control register
  assign chip_reset = power_up_reset_i | supply_drop_reset_i | pin_reset_i | dog_reset_o;

  // Selected time-out in oscillator cycles
  assign limit = BASE_LIMIT << timeout_select; // RL13

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  // The prescaler and the clear of enable look at the change-enable held
  // before this write, so a single write cannot open and use the window
  always_comb begin
    next_change_enable = change_enable;
    next_dog_enable = dog_enable;
    next_timeout_select = timeout_select;
    next_ce_count = ce_count;
    if (change_enable) begin
      if (ce_count == '0) begin
        next_change_enable = 1'b0; // RL9
      end else begin
        next_ce_count = ce_count - CE_W'(1);
      end
    end
    if (ctrl_wr) begin
      next_change_enable = io_wdata_i[CHANGE_ENABLE_BIT]; // RL9
      if (io_wdata_i[CHANGE_ENABLE_BIT]) begin
        next_ce_count = CE_LOAD;
      end
      if (io_wdata_i[DOG_ENABLE_BIT]) begin
        next_dog_enable = 1'b1; // RL10
      end else if (change_enable) begin
        next_dog_enable = 1'b0; // RL10
      end
      if (change_enable) begin
        next_timeout_select = io_wdata_i[TIMEOUT_SELECT_MSB:0]; // RL12
      end
    end
    if (chip_reset) begin
      next_change_enable = CTRL_RESET[CHANGE_ENABLE_BIT];
      next_dog_enable = CTRL_RESET[DOG_ENABLE_BIT];
      next_timeout_select = CTRL_RESET[TIMEOUT_SELECT_MSB:0];
      next_ce_count = '0;
    end
    if (always_on_fuse_i) begin
      next_dog_enable = 1'b1; // RL16
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      change_enable <= CTRL_RESET[CHANGE_ENABLE_BIT];
      dog_enable <= CTRL_RESET[DOG_ENABLE_BIT];
      timeout_select <= CTRL_RESET[TIMEOUT_SELECT_MSB:0];
      ce_count <= '0;
    end else begin
      change_enable <= next_change_enable;
      dog_enable <= next_dog_enable;
      timeout_select <= next_timeout_select;
      ce_count <= next_ce_count;
    end
  end

  // ---------------------------------------------------------------
  // Reset-cause flags
  // ---------------------------------------------------------------
  // Software write applies first and reset events override it, so an event
  // in the cycle of a clearing write is never lost
  always_comb begin
    next_cause_flags = cause_flags;
    if (flags_wr) begin
      next_cause_flags = io_wdata_i[3:0]; // RL18
    end
    if (power_up_reset_i) begin
      next_cause_flags[DOG_RESET_FLAG_BIT] = 1'b0; // RL1
      next_cause_flags[SUPPLY_DROP_FLAG_BIT] = 1'b0; // RL2
      next_cause_flags[PIN_RESET_FLAG_BIT] = 1'b0; // RL3
      next_cause_flags[POWER_UP_FLAG_BIT] = 1'b1; // RL4
    end
    if (dog_reset_o) begin
      next_cause_flags[DOG_RESET_FLAG_BIT] = 1'b1; // RL1
    end
    if (supply_drop_reset_i) begin
      next_cause_flags[SUPPLY_DROP_FLAG_BIT] = 1'b1; // RL2
    end
    if (pin_reset_i) begin
      next_cause_flags[PIN_RESET_FLAG_BIT] = 1'b1; // RL3
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cause_flags <= FLAGS_RESET[3:0]; // RL7
    end else begin
      cause_flags <= next_cause_flags;
    end
  end

  // ---------------------------------------------------------------
  // Time-out counter
  // ---------------------------------------------------------------
  // The count clears to zero on the expiry cycle; the pulse then resets the control register and count
  always_comb begin
    next_dog_count = dog_count;
    next_dog_reset = 1'b0;
    if (chip_reset || !dog_enable || dog_restart_instruction_i) begin
      next_dog_count = '0; // RL15
    end else if (osc_tick) begin
      if (dog_count >= limit - TIMEOUT_COUNT_W'(1)) begin
        next_dog_reset = 1'b1; // RL19
        next_dog_count = '0;
      end else begin
        next_dog_count = dog_count + TIMEOUT_COUNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dog_count <= '0;
      dog_reset_o <= 1'b0;
    end else begin
      dog_count <= next_dog_count;
      dog_reset_o <= next_dog_reset; // RL14
    end
  end

  // ---------------------------------------------------------------
  // Read data and status outputs
  // ---------------------------------------------------------------
  // Read data is registered: it appears the cycle after the read strobe
  // and holds until the next read; unmapped offsets return zero
  always_comb begin
    next_rdata = io_rdata_o;
    next_dog_enable_o = next_dog_enable;
    if (io_rd_i) begin
      next_rdata = 8'h00;
      if (hit && (offset == CTRL_OFFSET)) begin
        next_rdata = {3'h0, change_enable, dog_enable, timeout_select} & CTRL_USED_MASK; // RL18
      end else if (hit && (offset == FLAGS_OFFSET)) begin
        next_rdata = {4'h0, cause_flags} & FLAGS_USED_MASK; // RL18
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      io_rdata_o <= 8'h00;
      dog_enable_o <= 1'b0;
    end else begin
      io_rdata_o <= next_rdata;
      dog_enable_o <= next_dog_enable_o;
    end
  end

endmodule

// ### dv/tb_wdr_top.sv
// Testbench: register accesses, reset-cause events and watchdog time-outs
`timescale 1ns/1ps
module tb_wdr_top;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [6:0] io_addr_i = 7'h00;
  logic io_data_space_i = 1'b0;
  logic io_wr_i = 1'b0;
  logic io_rd_i = 1'b0;
  logic [7:0] io_wdata_i = 8'h00;
  logic [7:0] io_rdata_o;
  logic [2:0] evt = 3'h0; // Power-up, supply drop, pin
  logic restart = 1'b0;
  logic fuse = 1'b0;
  logic dog_reset_o;
  logic dog_enable_o;
  logic hit;
  int failures = 0;
  int checks_done = 0;
  int n;

  always #4 clk_i = ~clk_i;

  // Short counts keep every time-out under a few thousand clocks
  wdr_top #(.TIMEOUT_BASE(4), .OSC_DIV(2)) i_wdr_top (.clk_i(clk_i), .rstn_i(rstn_i),
    .io_addr_i(io_addr_i), .io_data_space_i(io_data_space_i), .io_wr_i(io_wr_i),
    .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
    .power_up_reset_i(evt[2]), .supply_drop_reset_i(evt[1]), .pin_reset_i(evt[0]),
    .dog_restart_instruction_i(restart), .always_on_fuse_i(fuse),
    .dog_reset_o(dog_reset_o), .dog_enable_o(dog_enable_o));

  // ---------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------
  task automatic give_verdict();
    if (failures == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge clk_i);
  endtask

  // Strobes last one cycle and drop at the next falling edge
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk_i);
    io_data_space_i = 1'b0;
    io_addr_i = a;
    io_wdata_i = d;
    io_wr_i = 1'b1;
    @(negedge clk_i);
    io_wr_i = 1'b0;
  endtask

  task automatic rd(input logic ds, input logic [6:0] a, input logic [7:0] e, input string w);
    @(negedge clk_i);
    io_data_space_i = ds;
    io_addr_i = a;
    io_rd_i = 1'b1;
    @(negedge clk_i);
    io_rd_i = 1'b0;
    chk(io_rdata_o, e, w);
  endtask

  task automatic pulse(input logic [2:0] m);
    @(negedge clk_i);
    evt = m;
    @(negedge clk_i);
    evt = 3'h0;
  endtask

  // Bounded wait; a hang ends the run as a failure
  task automatic wait_dog(output int k);
    k = 0;
    while (dog_reset_o !== 1'b1 && k < 3000) begin
      @(negedge clk_i);
      k++;
    end
    if (k >= 3000) begin
      failures++;
      give_verdict();
    end
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    cyc(2);
    rstn_i = 1'b1;
    rd(1'b1, 7'h41, 8'h00, "ctrl reset");
    rd(1'b1, 7'h54, 8'h00, "flags reset");
    rd(1'b0, 7'h60, 8'h00, "unmapped");
    pulse(3'b100);
    rd(1'b0, 7'h34, 8'h01, "power flag");
    pulse(3'b001);
    rd(1'b0, 7'h34, 8'h03, "pin flag");
    pulse(3'b010);
    rd(1'b0, 7'h34, 8'h07, "drop flag");
    pulse(3'b100);
    rd(1'b0, 7'h34, 8'h01, "power clears");
    wr(7'h34, 8'hFF);
    pulse(3'b011);
    rd(1'b0, 7'h34, 8'h0F, "flags upper");
    wr(7'h34, 8'h00);
    rd(1'b0, 7'h34, 8'h00, "flags cleared");
    // Enable and select behind the change window; restart is held so the
    // shortened time-out cannot fire in the middle of the sequence
    restart = 1'b1;
    wr(7'h21, 8'h0F);
    rd(1'b0, 7'h21, 8'h08, "select locked");
    wr(7'h21, 8'h00);
    rd(1'b0, 7'h21, 8'h08, "enable kept");
    chk({7'h0, dog_enable_o}, 8'h01, "enable pin on");
    wr(7'h21, 8'hF8);
    rd(1'b0, 7'h21, 8'h18, "window open");
    cyc(2);
    rd(1'b0, 7'h21, 8'h08, "window shut");
    wr(7'h21, 8'h18);
    cyc(3);
    wr(7'h21, 8'h00);
    rd(1'b0, 7'h21, 8'h08, "late disable");
    wr(7'h21, 8'h18);
    wr(7'h21, 8'h0B);
    rd(1'b0, 7'h21, 8'h0B, "select change");
    wr(7'h21, 8'h18);
    cyc(2);
    wr(7'h21, 8'h00);
    rd(1'b0, 7'h21, 8'h00, "last cycle disable");
    chk({7'h0, dog_enable_o}, 8'h00, "enable pin off");
    restart = 1'b0;
    // Every select code doubles the time-out
    for (int s = 0; s < 8; s++) begin
      wr(7'h21, 8'h10);
      wr(7'h21, 8'h08 | 8'(s));
      wait_dog(n);
      chk({7'h0, n >= (8 << s) - 4 && n <= (8 << s) + 4}, 8'h01, "timeout");
      rd(1'b0, 7'h34, 8'h08, "dog flag");
      rd(1'b0, 7'h21, 8'h00, "ctrl after dog");
      wr(7'h34, 8'h00);
    end
    // Restarts every four clocks hold off a limit of eight
    wr(7'h21, 8'h08);
    hit = 1'b0;
    for (int i = 0; i < 40; i++) begin
      @(negedge clk_i);
      restart = (i % 4 == 0);
      hit = hit | dog_reset_o;
    end
    restart = 1'b0;
    chk({7'h0, hit}, 8'h00, "restart");
    wait_dog(n);
    fuse = 1'b1;
    wr(7'h21, 8'h18);
    wr(7'h21, 8'h02);
    rd(1'b0, 7'h21, 8'h0A, "fuse");
    give_verdict();
  end
endmodule

// ### dv/wdr_top_asserts.sv
// Checker: port assertions for the watchdog and reset-cause flag block
`timescale 1ns/1ps
module wdr_checker (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [6:0] io_addr_i,
  input wire logic io_data_space_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_rdata_o,
  input wire logic power_up_reset_i,
  input wire logic supply_drop_reset_i,
  input wire logic pin_reset_i,
  input wire logic always_on_fuse_i,
  input wire logic dog_reset_o,
  input wire logic dog_enable_o
);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // Any power-up, supply-drop or pin reset event; they all wipe the control register
  logic chip_evt;
  assign chip_evt = power_up_reset_i | supply_drop_reset_i | pin_reset_i;

  pulse_one_cycle_a: assert property (dog_reset_o |=> !dog_reset_o)
    else $error("dog reset pulse longer than one cycle");
  dog_disables_a: assert property (dog_reset_o && !always_on_fuse_i |=> !dog_enable_o)
    else $error("enable survived own time-out");
  event_disables_a: assert property (chip_evt && !always_on_fuse_i |=> !dog_enable_o)
    else $error("enable survived chip reset event");
  fuse_keeps_on_a: assert property ($past(always_on_fuse_i) && $past(rstn_i) |-> dog_enable_o)
    else $error("enable low with fuse set");
  idle_no_dog_a: assert property (!dog_enable_o |=> !dog_reset_o)
    else $error("time-out while disabled");
  dog_needs_en_a: assert property ($rose(dog_reset_o) |-> $past(dog_enable_o))
    else $error("time-out without prior enable");
  unmapped_zero_a: assert property (io_rd_i && !io_data_space_i && io_addr_i > 7'h3F
    |=> io_rdata_o == 8'h00)
    else $error("out of range read not zero");
  upper_zero_a: assert property (io_rd_i |=> io_rdata_o[7:5] == 3'b000)
    else $error("upper read bits not zero");
  enable_kept_a: assert property (dog_enable_o && !io_wr_i && !dog_reset_o && !chip_evt
    |=> dog_enable_o)
    else $error("enable dropped without cause");

  cover property (dog_reset_o);
  cover property ($fell(dog_enable_o) && !$past(dog_reset_o));
  cover property (io_rd_i && io_data_space_i);
endmodule

bind wdr_top wdr_checker i_wdr_checker (.clk_i(clk_i), .rstn_i(rstn_i),
  .io_addr_i(io_addr_i), .io_data_space_i(io_data_space_i), .io_wr_i(io_wr_i),
  .io_rd_i(io_rd_i), .io_rdata_o(io_rdata_o), .power_up_reset_i(power_up_reset_i),
  .supply_drop_reset_i(supply_drop_reset_i), .pin_reset_i(pin_reset_i),
  .always_on_fuse_i(always_on_fuse_i), .dog_reset_o(dog_reset_o),
  .dog_enable_o(dog_enable_o));
